// *** core/wdr_defines.svh ***
`ifndef WDR_DEFINES_SVH
`define WDR_DEFINES_SVH

// register port offsets
`define WDR_REG_CMD    4'h0
`define WDR_REG_OPA    4'h1
`define WDR_REG_OPB    4'h2
`define WDR_REG_OPC    4'h3
`define WDR_REG_STATUS 4'h4
`define WDR_REG_IST    4'h5
`define WDR_REG_IMASK  4'h6
`define WDR_REG_RXCNT0 4'h7
`define WDR_REG_RXCNT1 4'h8
`define WDR_REG_MEMA   4'h9
`define WDR_REG_MEMD   4'ha

// field positions
`define WDR_CMD_COND   2
`define WDR_IND_BIT    15
`define WDR_IRQ_DONE   0
`define WDR_IRQ_ERR    1
`define WDR_IRQ_RX0    2

// word address map: work area, then data memory with a protected top
`define WDR_WORK_END   13'h03ff
`define WDR_DM_BASE    13'h0400
`define WDR_PROT_LO    13'h1800
`define WDR_MEM_TOP    13'h19ff
`define WDR_DM_WORDS   14'h1600
`define WDR_AREA_WORK  2'h0
`define WDR_AREA_DM    2'h1
`define WDR_AREA_NONE  2'h3

// digit and byte limits
`define WDR_DIGIT_MAX  4'h3
`define WDR_RX_MAX     9'h100
`define WDR_RX_MAX_BCD 14'h0100

`endif

// *** core/wdr_pkg.sv ***
`default_nettype none
package wdr_pkg;
	typedef enum logic [1:0] {
		WDR_OP_NONE = 2'h0,
		WDR_OP_MOVD = 2'h1,
		WDR_OP_XFER = 2'h2,
		WDR_OP_RXD  = 2'h3
	} wdr_op_t;

	typedef enum logic [5:0] {
		WDR_ST_IDLE    = 6'h01,
		WDR_ST_RESOLVE = 6'h02,
		WDR_ST_CHECK   = 6'h04,
		WDR_ST_COPY    = 6'h08,
		WDR_ST_RECV    = 6'h10,
		WDR_ST_FIN     = 6'h20
	} wdr_state_t;

	// one received byte from a port's receiver, same clock domain
	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} wdr_rx_t;

	// resolved operand reference
	typedef struct packed {
		logic [12:0] addr;
		logic        bad;
	} wdr_ref_t;
endpackage
`default_nettype wire

// *** core/wdr_unit.sv ***
// Design decisions made here: the address map and the address-and-strobe port.
`include "wdr_defines.svh"
`default_nettype none
module wdr_unit
	import wdr_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic [3:0]        REG_ADDR,
	input  wire logic [15:0]       REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output logic      [15:0]       REG_RDATA,
	input  wire wdr_rx_t [1:0]     RX_IN,
	output logic      [1:0]        RX_READY,
	output logic                   RS232_RX_DONE,
	output logic                   PERIPH_RX_DONE,
	output logic                   OP_ERROR,
	output logic                   IRQ
);
	logic [15:0] mem [0:`WDR_MEM_TOP];
	logic [7:0]  rx_buf [0:1][0:255];
	logic [8:0]  rx_cnt_ff [0:1];
	logic [7:0]  rx_wr_ff  [0:1];
	logic [7:0]  rx_rd_ff  [0:1];
	logic [1:0]  rx_done_ff;
	logic [1:0]  rx_clr;
	logic [1:0]  rx_evt;
	wdr_state_t  st_ff;
	wdr_op_t     op_ff;
	logic [15:0] opa_ff, opb_ff, opc_ff;
	logic [12:0] ra_ff, rb_ff, rc_ff;
	logic        res_bad_ff;
	logic        err_ff;
	logic [13:0] len_ff;
	logic [13:0] idx_ff;
	logic        port_ff;
	logic        order_ff;
	logic [3:0]  ist_ff, imask_ff;
	logic [12:0] mema_ff;
	logic [15:0] rdata_ff;
	logic        eng_we;
	logic [12:0] eng_wa;
	logic [15:0] eng_wd;
	logic        chk_bad;
	logic [13:0] chk_len;
	logic        idle;
	logic        sw_wr_cmd;
	wdr_ref_t    ref_a, ref_b, ref_c;

	function automatic logic [15:0] rd_mem(input logic [12:0] a);
		rd_mem = (a <= `WDR_MEM_TOP) ? mem[a] : 16'h0000;
	endfunction

	function automatic logic is_bcd(input logic [15:0] v);
		is_bcd = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v[11:8] <= 4'h9) && (v[15:12] <= 4'h9);
	endfunction

	function automatic logic [13:0] bcd2bin(input logic [15:0] v);
		bcd2bin = ((14'(v[15:12]) * 14'd10 + 14'(v[11:8])) * 14'd10 + 14'(v[7:4])) * 14'd10 + 14'(v[3:0]);
	endfunction

	function automatic logic [1:0] area_of(input logic [13:0] a);
		if (a <= {1'b0, `WDR_WORK_END})
			area_of = `WDR_AREA_WORK;
		else if (a <= {1'b0, `WDR_MEM_TOP})
			area_of = `WDR_AREA_DM;
		else
			area_of = `WDR_AREA_NONE;
	endfunction

	// whole range inside one existing area; an empty range is always fine
	function automatic logic range_ok(input logic [12:0] s, input logic [13:0] n);
		logic [13:0] e;
		e = {1'b0, s} + n - 14'd1;
		range_ok = (n == 14'd0) ||
			((area_of({1'b0, s}) != `WDR_AREA_NONE) && (area_of(e) == area_of({1'b0, s})));
	endfunction

	// protected words sit at the top of data memory, so only the range end matters
	function automatic logic hits_prot(input logic [12:0] s, input logic [13:0] n);
		hits_prot = ({1'b0, s} + ((n == 14'd0) ? 14'd0 : n - 14'd1)) >= {1'b0, `WDR_PROT_LO};
	endfunction

	function automatic wdr_ref_t resolve(input logic [15:0] op);
		wdr_ref_t r;
		logic [15:0] ptr;
		logic [13:0] bin;
		ptr = rd_mem(op[12:0]);
		bin = bcd2bin(ptr);
		if (op[`WDR_IND_BIT]) begin
			r.bad  = !is_bcd(ptr) || (bin >= `WDR_DM_WORDS);
			r.addr = `WDR_DM_BASE + bin[12:0];
		end else begin
			r.bad  = op[12:0] > `WDR_MEM_TOP;
			r.addr = op[12:0];
		end
		resolve = r;
	endfunction

	// digit copy with 2-bit index wrap; count field holds digits minus one
	function automatic logic [15:0] movd(input logic [15:0] s, input logic [15:0] d, input logic [15:0] di);
		logic [15:0] r;
		logic [1:0]  si;
		logic [1:0]  dn;
		r  = d;
		si = di[1:0];
		dn = di[9:8];
		for (int k = 0; k < 4; k++) begin
			if (3'(k) <= {1'b0, di[5:4]}) begin
				r[{dn, 2'b00} +: 4] = s[{si, 2'b00} +: 4];
				si = si + 2'h1;
				dn = dn + 2'h1;
			end
		end
		movd = r;
	endfunction

	assign idle      = (st_ff == WDR_ST_IDLE);
	assign sw_wr_cmd = REG_WR && (REG_ADDR == `WDR_REG_CMD) && idle;
	assign ref_a     = resolve(opa_ff);
	assign ref_b     = resolve(opb_ff);
	assign ref_c     = resolve(opc_ff);

	// operand checks per operation, evaluated in the check state
	always_comb begin
		logic [15:0] v;
		logic [13:0] n;
		logic [13:0] words;
		logic [8:0]  have;
		v = 16'h0000;
		n = 14'd0;
		words = 14'd0;
		have = 9'h000;
		chk_bad = res_bad_ff;
		chk_len = 14'd0;
		unique case (op_ff)
			WDR_OP_MOVD: begin
				v = rd_mem(rb_ff);
				if (v[3:0] > `WDR_DIGIT_MAX || v[7:4] > `WDR_DIGIT_MAX || v[11:8] > `WDR_DIGIT_MAX)
					chk_bad = 1'b1;
				if (hits_prot(rb_ff, 14'd1) || hits_prot(rc_ff, 14'd1))
					chk_bad = 1'b1;
			end
			WDR_OP_XFER: begin
				v = rd_mem(ra_ff);
				n = bcd2bin(v);
				if (!is_bcd(v) || !range_ok(rb_ff, n) || !range_ok(rc_ff, n))
					chk_bad = 1'b1;
				if (n != 14'd0 && hits_prot(rc_ff, n))
					chk_bad = 1'b1;
				chk_len = n;
			end
			WDR_OP_RXD: begin
				v = rd_mem(rc_ff);
				n = bcd2bin(v);
				have = rx_cnt_ff[opb_ff[4]];
				if (!is_bcd(v) || n > `WDR_RX_MAX_BCD || hits_prot(rc_ff, 14'd1))
					chk_bad = 1'b1;
				if (opb_ff[3:1] != 3'h0 || opb_ff[7:5] != 3'h0 || opb_ff[15:8] != 8'h00)
					chk_bad = 1'b1;
				chk_len = (n < {5'h00, have}) ? n : {5'h00, have}; // fewer held: take what is there
				words = (chk_len + 14'd1) >> 1;
				if (!range_ok(ra_ff, words) || (words != 14'd0 && hits_prot(ra_ff, words)))
					chk_bad = 1'b1;
			end
			default: chk_bad = 1'b1;
		endcase
	end

	// engine write port: digit move, word copy or packed receive word
	always_comb begin
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] p;
		p  = rx_rd_ff[port_ff] + {idx_ff[6:0], 1'b0};
		b0 = rx_buf[port_ff][p];
		b1 = ({idx_ff[12:0], 1'b1} < len_ff) ? rx_buf[port_ff][p + 8'h01] : 8'h00;
		eng_we = 1'b0;
		eng_wa = rc_ff;
		eng_wd = 16'h0000;
		if (st_ff == WDR_ST_CHECK && op_ff == WDR_OP_MOVD && !chk_bad) begin
			eng_we = 1'b1;
			eng_wd = movd(rd_mem(ra_ff), rd_mem(rc_ff), rd_mem(rb_ff));
		end else if (st_ff == WDR_ST_COPY && idx_ff != len_ff) begin
			eng_we = 1'b1;
			eng_wa = rc_ff + idx_ff[12:0];
			eng_wd = rd_mem(rb_ff + idx_ff[12:0]);
		end else if (st_ff == WDR_ST_RECV && {idx_ff[12:0], 1'b0} < len_ff) begin
			eng_we = 1'b1;
			eng_wa = ra_ff + idx_ff[12:0];
			eng_wd = order_ff ? {b1, b0} : {b0, b1};
		end
	end

	// memory: software writes only while the engine is idle
	always_ff @(posedge CLK) begin
		if (eng_we)
			mem[eng_wa] <= eng_wd;
		else if (REG_WR && REG_ADDR == `WDR_REG_MEMD && idle && mema_ff <= `WDR_MEM_TOP)
			mem[mema_ff] <= REG_WDATA;
	end

	// operation sequencer
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			st_ff      <= WDR_ST_IDLE;
			op_ff      <= WDR_OP_NONE;
			res_bad_ff <= 1'b0;
			err_ff     <= 1'b0;
			ra_ff      <= 13'h0000;
			rb_ff      <= 13'h0000;
			rc_ff      <= 13'h0000;
			len_ff     <= 14'd0;
			idx_ff     <= 14'd0;
			port_ff    <= 1'b0;
			order_ff   <= 1'b0;
		end else begin
			unique case (st_ff)
				WDR_ST_IDLE: begin
					// condition false: nothing starts, flags keep their state
					if (sw_wr_cmd && REG_WDATA[`WDR_CMD_COND] && REG_WDATA[1:0] != WDR_OP_NONE) begin
						op_ff  <= wdr_op_t'(REG_WDATA[1:0]);
						err_ff <= 1'b0;
						st_ff  <= WDR_ST_RESOLVE;
					end
				end
				WDR_ST_RESOLVE: begin
					ra_ff      <= ref_a.addr;
					rb_ff      <= ref_b.addr;
					rc_ff      <= ref_c.addr;
					// receive control is an immediate, never resolved
					res_bad_ff <= ref_a.bad || ref_c.bad || (op_ff != WDR_OP_RXD && ref_b.bad);
					st_ff      <= WDR_ST_CHECK;
				end
				WDR_ST_CHECK: begin
					len_ff   <= chk_len;
					idx_ff   <= 14'd0;
					port_ff  <= opb_ff[4];
					order_ff <= opb_ff[0];
					if (chk_bad) begin
						err_ff <= 1'b1;
						st_ff  <= WDR_ST_FIN;
					end else if (op_ff == WDR_OP_XFER)
						st_ff <= WDR_ST_COPY;
					else if (op_ff == WDR_OP_RXD)
						st_ff <= WDR_ST_RECV;
					else
						st_ff <= WDR_ST_FIN;
				end
				WDR_ST_COPY: begin
					// forward copy: overlap with destination above source smears data
					if (idx_ff == len_ff)
						st_ff <= WDR_ST_FIN;
					else
						idx_ff <= idx_ff + 14'd1;
				end
				WDR_ST_RECV: begin
					if ({idx_ff[12:0], 1'b0} >= len_ff)
						st_ff <= WDR_ST_FIN;
					else
						idx_ff <= idx_ff + 14'd1;
				end
				WDR_ST_FIN: st_ff <= WDR_ST_IDLE;
			endcase
		end
	end

	// a receive that finishes without error empties the selected port; a failed one leaves it full
	assign rx_clr[0] = (st_ff == WDR_ST_FIN) && (op_ff == WDR_OP_RXD) && !err_ff && !port_ff;
	assign rx_clr[1] = (st_ff == WDR_ST_FIN) && (op_ff == WDR_OP_RXD) && !err_ff && port_ff;

	// per-port receive buffers
	for (genvar p = 0; p < 2; p++) begin : g_port
		logic blocked;
		assign blocked     = !idle && (op_ff == WDR_OP_RXD) && (opb_ff[4] == 1'(p));
		assign RX_READY[p] = (rx_cnt_ff[p] < `WDR_RX_MAX) && !blocked;
		assign rx_evt[p]   = RX_IN[p].valid && RX_READY[p] && RX_IN[p].last;

		always_ff @(posedge CLK) begin
			if (RX_IN[p].valid && RX_READY[p])
				rx_buf[p][rx_wr_ff[p]] <= RX_IN[p].data;
		end

		always_ff @(posedge CLK) begin
			if (!RST_N) begin
				rx_cnt_ff[p]  <= 9'h000;
				rx_wr_ff[p]   <= 8'h00;
				rx_rd_ff[p]   <= 8'h00;
				rx_done_ff[p] <= 1'b0;
			end else begin
				if (RX_IN[p].valid && RX_READY[p]) begin
					rx_wr_ff[p]  <= rx_wr_ff[p] + 8'h01;
					rx_cnt_ff[p] <= rx_cnt_ff[p] + 9'h001;
				end
				if (rx_clr[p]) begin
					rx_cnt_ff[p] <= 9'h000;
					rx_rd_ff[p]  <= rx_wr_ff[p];
				end
				// a finished message beats a clear in the same cycle
				if (rx_evt[p])
					rx_done_ff[p] <= 1'b1;
				else if (rx_clr[p])
					rx_done_ff[p] <= 1'b0;
			end
		end
	end

	// software-visible setup registers; operands frozen while an operation runs, address and mask always writable
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			opa_ff   <= 16'h0000;
			opb_ff   <= 16'h0000;
			opc_ff   <= 16'h0000;
			mema_ff  <= 13'h0000;
			imask_ff <= 4'h0;
		end else if (REG_WR) begin
			if (idle && REG_ADDR == `WDR_REG_OPA)
				opa_ff <= REG_WDATA;
			if (idle && REG_ADDR == `WDR_REG_OPB)
				opb_ff <= REG_WDATA;
			if (idle && REG_ADDR == `WDR_REG_OPC)
				opc_ff <= REG_WDATA;
			if (REG_ADDR == `WDR_REG_MEMA)
				mema_ff <= REG_WDATA[12:0];
			if (REG_ADDR == `WDR_REG_IMASK)
				imask_ff <= REG_WDATA[3:0];
		end
	end

	// sticky events, write one to clear, a new event wins
	always_ff @(posedge CLK) begin
		logic [3:0] set;
		logic [3:0] clr;
		set = {rx_evt, (st_ff == WDR_ST_FIN) && err_ff, st_ff == WDR_ST_FIN};
		clr = (REG_WR && REG_ADDR == `WDR_REG_IST) ? REG_WDATA[3:0] : 4'h0;
		if (!RST_N)
			ist_ff <= 4'h0;
		else
			ist_ff <= (ist_ff & ~clr) | set;
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge CLK) begin
		if (!RST_N)
			rdata_ff <= 16'h0000;
		else if (REG_RD) begin
			unique case (REG_ADDR)
				`WDR_REG_CMD:    rdata_ff <= {14'h0000, op_ff};
				`WDR_REG_OPA:    rdata_ff <= opa_ff;
				`WDR_REG_OPB:    rdata_ff <= opb_ff;
				`WDR_REG_OPC:    rdata_ff <= opc_ff;
				`WDR_REG_STATUS: rdata_ff <= {12'h000, rx_done_ff, err_ff, !idle};
				`WDR_REG_IST:    rdata_ff <= {12'h000, ist_ff};
				`WDR_REG_IMASK:  rdata_ff <= {12'h000, imask_ff};
				`WDR_REG_RXCNT0: rdata_ff <= {7'h00, rx_cnt_ff[0]};
				`WDR_REG_RXCNT1: rdata_ff <= {7'h00, rx_cnt_ff[1]};
				`WDR_REG_MEMA:   rdata_ff <= {3'h0, mema_ff};
				`WDR_REG_MEMD:   rdata_ff <= rd_mem(mema_ff);
				default:         rdata_ff <= 16'h0000;
			endcase
		end else
			rdata_ff <= 16'h0000;
	end

	assign REG_RDATA      = rdata_ff;
	assign RS232_RX_DONE  = rx_done_ff[0];
	assign PERIPH_RX_DONE = rx_done_ff[1];
	assign OP_ERROR       = err_ff;
	assign IRQ            = |(ist_ff & imask_ff);
endmodule
`default_nettype wire

// *** tb/wdr_unit_props.sv ***
`include "wdr_defines.svh"
`default_nettype none
module wdr_unit_chk
	import wdr_pkg::*;
(
	input wire logic          CLK,
	input wire logic          RST_N,
	input wire logic [3:0]    REG_ADDR,
	input wire logic [15:0]   REG_WDATA,
	input wire logic          REG_WR,
	input wire logic          REG_RD,
	input wire logic [15:0]   REG_RDATA,
	input wire wdr_rx_t [1:0] RX_IN,
	input wire logic [1:0]    RX_READY,
	input wire logic          RS232_RX_DONE,
	input wire logic          PERIPH_RX_DONE,
	input wire logic          OP_ERROR,
	input wire logic          IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] mask_ff;
	logic [3:0] age_ff;

	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);

	// shadow of the mask, fed from the bus alone
	always_ff @(posedge CLK) begin
		if (!RST_N)
			mask_ff <= 4'h0;
		else if (REG_WR && REG_ADDR == `WDR_REG_IMASK)
			mask_ff <= REG_WDATA[3:0];
	end

	// cycles since an enabled command, saturating so it never wraps
	always_ff @(posedge CLK) begin
		if (!RST_N || (REG_WR && REG_ADDR == `WDR_REG_CMD && REG_WDATA[`WDR_CMD_COND]))
			age_ff <= 4'h0;
		else if (age_ff != 4'hf)
			age_ff <= age_ff + 4'h1;
	end

	sequence s_rd(a);
		REG_RD && REG_ADDR == a;
	endsequence

	sequence s_last(p);
		RX_IN[p].valid && RX_IN[p].last && RX_READY[p];
	endsequence

	a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 16'h0000)
		else $error("read data outside its cycle");
	a_unmapped_zero: assert property (REG_RD && REG_ADDR > `WDR_REG_MEMD |=> REG_RDATA == 16'h0000)
		else $error("unmapped read not zero");
	a_status_flags: assert property (s_rd(`WDR_REG_STATUS) |=>
		REG_RDATA[15:1] == {12'h000, $past(PERIPH_RX_DONE), $past(RS232_RX_DONE), $past(OP_ERROR)})
		else $error("status word disagrees with flags");
	a_count_cap: assert property ((s_rd(`WDR_REG_RXCNT0) or s_rd(`WDR_REG_RXCNT1)) |=>
		REG_RDATA <= 16'h0100)
		else $error("byte count above 256");
	a_done0_set: assert property (s_last(0) |=> RS232_RX_DONE)
		else $error("port 0 done flag not set");
	a_done1_set: assert property (s_last(1) |=> PERIPH_RX_DONE)
		else $error("port 1 done flag not set");
	a_done_cause: assert property ($rose(RS232_RX_DONE) |->
		$past(RX_IN[0].valid && RX_IN[0].last && RX_READY[0]))
		else $error("port 0 done without end byte");
	a_err_cause: assert property ($rose(OP_ERROR) |-> age_ff < 4'h8)
		else $error("error flag rose without command");
	a_irq_level: assert property (s_rd(`WDR_REG_IST) |=>
		$past(IRQ) == |(REG_RDATA[3:0] & $past(mask_ff)))
		else $error("interrupt line disagrees with status");
endmodule

bind wdr_unit wdr_unit_chk u_chk (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RX_IN(RX_IN), .RX_READY(RX_READY),
	.RS232_RX_DONE(RS232_RX_DONE), .PERIPH_RX_DONE(PERIPH_RX_DONE), .OP_ERROR(OP_ERROR), .IRQ(IRQ));
`default_nettype wire

// *** tb/wdr_serial_dev.sv ***
`default_nettype none
module wdr_serial_dev
	import wdr_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic [1:0]    rx_ready,
	output var  wdr_rx_t [1:0] rx_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int         left [2];
	logic [7:0] val  [2];
	logic       slow [2];
	logic       ends [2];
	logic       gap  [2];

	// one always block drives every word, reset and idle alike, so the port has a single driver
	// queue n bytes counting up from first; slow leaves a gap after each
	task automatic start(input int p, input int n, input logic [7:0] first, input logic sl, input logic en);
		left[p] = n;
		val[p] = first;
		slow[p] = sl;
		ends[p] = en;
	endtask

	// a refused byte is held unchanged; idle data toggles so it is never stale
	always @(posedge clk) begin
		for (int p = 0; p < 2; p++) begin
			if (!rst_n) begin
				left[p] = 0;
				val[p] = 8'h00;
				slow[p] = 1'b0;
				ends[p] = 1'b0;
				gap[p] = 1'b0;
				rx_in[p] <= '0;
			end else if (!rx_in[p].valid || rx_ready[p]) begin
				if (rx_in[p].valid) begin
					left[p]--;
					val[p]++;
				end
				gap[p] = slow[p] && !gap[p];
				if (left[p] > 0 && !gap[p])
					rx_in[p] <= '{1'b1, ends[p] && left[p] == 1, val[p]};
				else
					rx_in[p] <= '{1'b0, 1'b0, ~rx_in[p].data};
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/word_digit_move_and_rx_unit_tb.sv ***
`include "wdr_defines.svh"
`default_nettype none
module word_digit_move_and_rx_unit_tb
	import wdr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic          clk;
	logic          rst_n;
	logic [3:0]    reg_addr;
	logic [15:0]   reg_wdata;
	logic          reg_wr;
	logic          reg_rd;
	logic [15:0]   reg_rdata;
	wdr_rx_t [1:0] rx_in;
	logic [1:0]    rx_ready;
	logic          rs_done;
	logic          pe_done;
	logic          op_err;
	logic          irq;
	int            errors;
	int            n_compared;
	int            cyc;
	int            seed;
	logic [15:0]   v, s, d, di, e;
	logic [15:0]   w [3];
	logic [7:0]    b0;

	wdr_unit dut (.CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_RDATA(reg_rdata), .RX_IN(rx_in), .RX_READY(rx_ready), .RS232_RX_DONE(rs_done),
		.PERIPH_RX_DONE(pe_done), .OP_ERROR(op_err), .IRQ(irq));
	wdr_serial_dev dev (.clk(clk), .rst_n(rst_n), .rx_ready(rx_ready), .rx_in(rx_in));

	always #2.5 clk = ~clk;

	// hang guard, far above the thousand or so cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			errors++;
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] dat);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= dat;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rdv(input logic [3:0] a, output logic [15:0] val);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 val = reg_rdata;
	endtask

	task automatic mwr(input logic [15:0] a, input logic [15:0] dat);
		wr(`WDR_REG_MEMA, a);
		wr(`WDR_REG_MEMD, dat);
	endtask

	task automatic mchk(input logic [15:0] a, input logic [15:0] exp);
		wr(`WDR_REG_MEMA, a);
		rdv(`WDR_REG_MEMD, v);
		chk(v, exp);
	endtask

	// load operands, launch, then poll busy under a bound
	task automatic run(input logic [15:0] cmd, a, b, c);
		wr(`WDR_REG_OPA, a);
		wr(`WDR_REG_OPB, b);
		wr(`WDR_REG_OPC, c);
		wr(`WDR_REG_CMD, cmd);
		for (int i = 0; i < 100; i++) begin
			rdv(`WDR_REG_STATUS, v);
			if (v[0] === 1'b0)
				return;
		end
		chk(v & 16'h0001, 16'h0000);
	endtask

	function automatic logic [15:0] dmove(input logic [15:0] src, dst, des);
		logic [15:0] r;
		r = dst;
		for (int k = 0; k <= int'(des[5:4]); k++)
			r[4 * ((des[9:8] + k) % 4) +: 4] = src[4 * ((des[1:0] + k) % 4) +: 4];
		return r;
	endfunction

	function automatic logic [15:0] rxw(input logic [7:0] first, input int j, input int n, input int o);
		logic [7:0] lo;
		logic [7:0] hi;
		hi = first + 8'(2 * j);
		lo = (2 * j + 1 < n) ? hi + 8'h01 : 8'h00;
		return (o == 1) ? {lo, hi} : {hi, lo};
	endfunction

	initial begin
		seed = 32'hffd2;
		clk = 1'b0;
		rst_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk({14'h0, rx_ready}, 16'h0003);
		rdv(`WDR_REG_STATUS, v);
		chk(v, 16'h0000);
		rdv(4'hf, v);
		chk(v, 16'h0000);
		// digit moves: the wrap case and random designators
		for (int i = 0; i < 8; i++) begin
			s = 16'($random(seed));
			d = 16'($random(seed));
			di = (i == 0) ? 16'h0201 : (i == 1) ? 16'h0332 : 16'($random(seed)) & 16'h0333;
			mwr(16'h0400, s);
			mwr(16'h0401, di);
			mwr(16'h0402, d);
			run(16'h0005, 16'h0400, 16'h0401, 16'h0402);
			mchk(16'h0402, dmove(s, d, di));
			chk({15'h0, op_err}, 16'h0000);
		end
		e = dmove(s, d, di);
		mwr(16'h0401, 16'h0041);
		run(16'h0005, 16'h0400, 16'h0401, 16'h0402);
		chk({15'h0, op_err}, 16'h0001);
		mwr(16'h0401, 16'h0201);
		run(16'h0005, 16'h0400, 16'h0401, 16'h1800);
		chk({15'h0, op_err}, 16'h0001);
		mwr(16'h0410, 16'h00a0);
		run(16'h0005, 16'h8410, 16'h0401, 16'h0402);
		chk({15'h0, op_err}, 16'h0001);
		run(16'h0001, 16'h0400, 16'h0401, 16'h0402);
		chk({15'h0, op_err}, 16'h0001);
		mchk(16'h0402, e);
		// interrupt: sticky events, masked, then cleared by a one
		rdv(`WDR_REG_IST, v);
		chk(v & 16'h0003, 16'h0003);
		chk({15'h0, irq}, 16'h0000);
		wr(`WDR_REG_IMASK, 16'h0002);
		#1 chk({15'h0, irq}, 16'h0001);
		wr(`WDR_REG_IST, 16'h0002);
		#1 chk({15'h0, irq}, 16'h0000);
		// block transfer with a sentinel just past the end
		for (int i = 0; i < 3; i++) begin
			w[i] = 16'($random(seed));
			mwr(16'h0420 + 16'(i), w[i]);
		end
		mwr(16'h0433, 16'h5a5a);
		mwr(16'h0440, 16'h5a5a);
		mwr(16'h0405, 16'h0003);
		mwr(16'h0406, 16'h000a);
		run(16'h0006, 16'h0405, 16'h0420, 16'h0430);
		for (int i = 0; i < 3; i++)
			mchk(16'h0430 + 16'(i), w[i]);
		mchk(16'h0433, 16'h5a5a);
		run(16'h0006, 16'h0406, 16'h0420, 16'h0440);
		chk({15'h0, op_err}, 16'h0001);
		run(16'h0006, 16'h0405, 16'h03fe, 16'h0440);
		chk({15'h0, op_err}, 16'h0001);
		run(16'h0006, 16'h0405, 16'h0420, 16'h1800);
		chk({15'h0, op_err}, 16'h0001);
		run(16'h0002, 16'h0405, 16'h0420, 16'h0440);
		mchk(16'h0440, 16'h5a5a);
		rdv(`WDR_REG_CMD, v);
		chk(v, 16'h0002);
		// receive: port 0 upper-first odd count, port 1 lower-first stalled and cut short
		for (int q = 0; q < 2; q++) begin
			b0 = 8'($random(seed));
			dev.start(q, q ? 4 : 5, b0, q[0], 1'b1);
			repeat (40) @(posedge clk);
			#1 chk({15'h0, q ? pe_done : rs_done}, 16'h0001);
			rdv(q ? `WDR_REG_RXCNT1 : `WDR_REG_RXCNT0, v);
			chk(v, q ? 16'h0004 : 16'h0005);
			mwr(16'h0406, q ? 16'h0003 : 16'h0006);
			run(16'h0007, 16'h0450, q ? 16'h0011 : 16'h0000, 16'h0406);
			for (int j = 0; j < 3 - q; j++)
				mchk(16'h0450 + 16'(j), rxw(b0, j, q ? 3 : 5, q));
			chk({14'h0, pe_done, rs_done}, 16'h0000);
			rdv(q ? `WDR_REG_RXCNT1 : `WDR_REG_RXCNT0, v);
			chk(v, 16'h0000);
		end
		rdv(`WDR_REG_IST, v);
		chk(v & 16'h000c, 16'h000c);
		// port 0 filled to its limit while the device keeps offering
		dev.start(0, 257, 8'h00, 1'b0, 1'b0);
		repeat (300) @(posedge clk);
		#1 chk({15'h0, rx_ready[0]}, 16'h0000);
		rdv(`WDR_REG_RXCNT0, v);
		chk(v, 16'h0100);
		mwr(16'h0406, 16'h0002);
		run(16'h0007, 16'h0460, 16'h0000, 16'h0406);
		mchk(16'h0460, 16'h0001);
		rdv(`WDR_REG_RXCNT0, v);
		chk(v, 16'h0001);
		print_verdict();
	end
endmodule
`default_nettype wire
